//--- hdi_i2c_map.vh
// Constants for the haptic driver register port.
`ifndef HDI_I2C_MAP_VH
`define HDI_I2C_MAP_VH
// Bus addresses chosen by the select pin.
`define HDI_ADDR_ONE      7'h54
`define HDI_ADDR_TWO      7'h40
`define HDI_DEBUG_FLIP    7'h01
// Identity values are arbitrary.
`define HDI_PRODUCT       16'h5a5a
`define HDI_MAJOR         16'h0001
`define HDI_MINOR         16'h0000
// Register offsets.
`define HDI_OFS_PRODUCT   16'h0000
`define HDI_OFS_MAJOR     16'h0002
`define HDI_OFS_MINOR     16'h0004
`define HDI_OFS_STATUS    16'h1000
`define HDI_OFS_SETTINGS  16'h2000
`define HDI_OFS_THERMAL   16'h2001
`define HDI_OFS_CONTROL   16'h2002
`define HDI_OFS_HAPTIC    16'h2003
`define HDI_OFS_BRIDGE    16'h3000
`define HDI_OFS_PULSE     16'h3002
`define HDI_OFS_FREQ      16'h3004
`define HDI_OFS_TRACK     16'h3006
`define HDI_OFS_SHAPE     16'h3007
`define HDI_OFS_HIGH      16'h0001
// Reset values.
`define HDI_RST_SETTINGS  8'h22
`define HDI_RST_THERMAL   8'h1a
`define HDI_RST_BRIDGE    16'h353e
`define HDI_RST_PULSE     16'h4e20
`define HDI_RST_FREQ      16'h00aa
`define HDI_RST_TRACK     8'h50
`define HDI_RST_SHAPE     8'hc0
`define HDI_UNMAPPED      8'hee
// Field positions.
`define HDI_BIT_RECAL     2
`define HDI_BIT_TRIGGER   0
`define HDI_BIT_STOP      1
`define HDI_BIT_ACK_RST   0
`define HDI_BIT_SOFT_RST  1
// Timing.
`define HDI_CLK_MHZ       40
`define HDI_STRETCH_US    20
`define HDI_DEEP_US       450
`endif

//--- hdi_sync.v
// Two-stage synchroniser for pin inputs.
`timescale 1ns/10ps
`default_nettype none
module hdi_sync #(
  parameter WIDTH = 3
) (
  input  wire             i_clk_sys,
  input  wire             i_rst,
  input  wire [WIDTH-1:0] i_async,
  output reg  [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta;

  always @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      meta   <= {WIDTH{1'b1}};
      o_sync <= {WIDTH{1'b1}};
    end
    else
    begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule
`default_nettype wire

//--- hdi_recal.v
// Recalibration advisory flag with frequency drift check.
`timescale 1ns/10ps
`default_nettype none
module hdi_recal (
  input  wire        i_clk_sys,
  input  wire        i_rst,
  input  wire        i_wave_done,
  input  wire [15:0] i_freq_start,
  input  wire [15:0] i_freq_end,
  input  wire        i_clear,
  output reg         o_flag
);
  wire [15:0] diff;
  wire [17:0] diff_x4;
  wire        drift;

  assign diff = (i_freq_end > i_freq_start) ? i_freq_end - i_freq_start
                                            : i_freq_start - i_freq_end;
  assign diff_x4 = {diff, 2'b00};
  assign drift = diff_x4 > {2'b00, i_freq_start};

  always @(posedge i_clk_sys)
  begin
    if (i_rst)
      o_flag <= 1'b0;
    else if (i_wave_done && drift)
      o_flag <= 1'b1;
    else if (i_clear)
      o_flag <= 1'b0;
  end
endmodule
`default_nettype wire

//--- hdi_i2c_port.v
// I2C target port and register map of the haptic driver.
// Notes on behaviour
// - Flag sets when end frequency differs from start by over 25 percent.
// - Any bus write to the drive frequency register clears the flag unless a large drift sets it in the same cycle.
// - Sixteen-bit byte addresses, one data byte per address.
// - Wide registers sit low byte first at aligned addresses.
// - Bit rates up to 1 Mbit/s; addressing accepted at any time.
// - Select pin low picks first address, high picks second.
// - Primary address with its low bit flipped is also acknowledged.
// - Bytes flow from the pointer while the host acknowledges each.
// - Unmapped addresses read as 0xee.
// - Write: address, two pointer bytes, data; every byte acknowledged.
// - Writes to unmapped addresses are dropped.
// - In deep sleep the clock is held up to 450 us after address.
// - Otherwise stretching lasts 20 us.
// - The flag is bit 2 of the status register.
`timescale 1ns/10ps
`default_nettype none
`include "hdi_i2c_map.vh"
module hdi_i2c_port #(
  parameter [14:0] P_DEEP_STRETCH_CYC = `HDI_DEEP_US * `HDI_CLK_MHZ
) (
  // Clock and reset.
  input  wire        i_clk_sys,
  input  wire        i_rst,
  // Bus pins.
  input  wire        i_scl,
  output reg         o_scl_out,
  output reg         o_scl_oe,
  input  wire        i_sda,
  output reg         o_sda_out,
  output reg         o_sda_oe,
  input  wire        i_addr_sel,
  // Haptic engine status.
  input  wire        i_wave_done,
  input  wire [15:0] i_freq_start,
  input  wire [15:0] i_freq_end,
  input  wire        i_freq_upd,
  input  wire [15:0] i_freq_meas,
  input  wire        i_haptics_active,
  input  wire        i_deep_sleep_state,
  input  wire        i_over_temp,
  input  wire        i_over_cur,
  input  wire        i_reset_flag,
  // Configuration to the engine.
  output reg  [7:0]  o_system_settings,
  output reg  [7:0]  o_thermal_limit_settings,
  output reg  [15:0] o_bridge_setup,
  output reg  [15:0] o_pulse_rate_setting,
  output reg  [15:0] o_resonant_drive_frequency,
  output reg  [7:0]  o_resonance_tracking_setup,
  output reg  [7:0]  o_waveform_shape,
  // Command pulses and flag.
  output reg         o_trigger_pulse,
  output reg         o_stop_pulse,
  output reg         o_soft_reset_pulse,
  output reg         o_ack_reset_pulse,
  output wire        o_recal_flag
);
  localparam [14:0] NORM_CYC = `HDI_STRETCH_US * `HDI_CLK_MHZ;
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_ADDR  = 3'h1;
  localparam [2:0] ST_RA_HI = 3'h2;
  localparam [2:0] ST_RA_LO = 3'h3;
  localparam [2:0] ST_WDATA = 3'h4;
  localparam [2:0] ST_RDATA = 3'h5;
  localparam [15:0] ID_PRODUCT = `HDI_PRODUCT;
  localparam [15:0] ID_MAJOR   = `HDI_MAJOR;
  localparam [15:0] ID_MINOR   = `HDI_MINOR;
  localparam [15:0] OFS_FREQ   = `HDI_OFS_FREQ;

  wire [2:0]  pin_s;
  reg         scl_q;
  reg         sda_q;
  reg         sel;
  reg  [2:0]  state;
  reg  [3:0]  bitcnt;
  reg  [7:0]  shift;
  reg  [7:0]  rdbuf;
  reg  [15:0] ptr;
  reg  [14:0] stretch_cnt;
  reg         wr_stb;
  reg  [15:0] wr_addr;
  reg  [7:0]  wr_data;
  reg  [7:0]  rd_byte;
  wire [6:0]  prim;
  wire        match;
  wire        scl_rise;
  wire        scl_fall;
  wire        start_c;
  wire        stop_c;
  wire        freq_wr;
  wire [7:0]  status;

  // Pins pass two flops before use.
  hdi_sync #(
    .WIDTH (3)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_async   ({i_addr_sel, i_sda, i_scl}),
    .o_sync    (pin_s)
  );

  hdi_recal u_recal (
    .i_clk_sys    (i_clk_sys),
    .i_rst        (i_rst),
    .i_wave_done  (i_wave_done),
    .i_freq_start (i_freq_start),
    .i_freq_end   (i_freq_end),
    .i_clear      (freq_wr),
    .o_flag       (o_recal_flag)
  );

  assign scl_rise = pin_s[0] & ~scl_q;
  assign scl_fall = ~pin_s[0] & scl_q;
  assign start_c  = pin_s[0] & scl_q & sda_q & ~pin_s[1];
  assign stop_c   = pin_s[0] & scl_q & ~sda_q & pin_s[1];

  assign prim = sel ? `HDI_ADDR_TWO : `HDI_ADDR_ONE;
  assign match = (shift[7:1] == prim) ||
                 (shift[7:1] == (prim ^ `HDI_DEBUG_FLIP));

  assign freq_wr = wr_stb && (wr_addr[15:1] == OFS_FREQ[15:1]);

  assign status = {2'b00, i_over_temp, i_over_cur, i_deep_sleep_state,
                   o_recal_flag, i_haptics_active, i_reset_flag};

  always @*
  begin
    rd_byte = `HDI_UNMAPPED;
    case (ptr)
      `HDI_OFS_PRODUCT:                 rd_byte = ID_PRODUCT[7:0];
      `HDI_OFS_PRODUCT + `HDI_OFS_HIGH: rd_byte = ID_PRODUCT[15:8];
      `HDI_OFS_MAJOR:                   rd_byte = ID_MAJOR[7:0];
      `HDI_OFS_MAJOR + `HDI_OFS_HIGH:   rd_byte = ID_MAJOR[15:8];
      `HDI_OFS_MINOR:                   rd_byte = ID_MINOR[7:0];
      `HDI_OFS_MINOR + `HDI_OFS_HIGH:   rd_byte = ID_MINOR[15:8];
      `HDI_OFS_STATUS:                  rd_byte = status;
      `HDI_OFS_SETTINGS:                rd_byte = o_system_settings;
      `HDI_OFS_THERMAL:                 rd_byte = o_thermal_limit_settings;
      `HDI_OFS_CONTROL:                 rd_byte = 8'h00;
      `HDI_OFS_HAPTIC:                  rd_byte = 8'h00;
      `HDI_OFS_BRIDGE:                  rd_byte = o_bridge_setup[7:0];
      `HDI_OFS_BRIDGE + `HDI_OFS_HIGH:  rd_byte = o_bridge_setup[15:8];
      `HDI_OFS_PULSE:                   rd_byte = o_pulse_rate_setting[7:0];
      `HDI_OFS_PULSE + `HDI_OFS_HIGH:   rd_byte = o_pulse_rate_setting[15:8];
      `HDI_OFS_FREQ:
        rd_byte = o_resonant_drive_frequency[7:0];
      `HDI_OFS_FREQ + `HDI_OFS_HIGH:
        rd_byte = o_resonant_drive_frequency[15:8];
      `HDI_OFS_TRACK:                   rd_byte = o_resonance_tracking_setup;
      `HDI_OFS_SHAPE:                   rd_byte = o_waveform_shape;
      default:                          rd_byte = `HDI_UNMAPPED;
    endcase
  end

  // Serial protocol engine.
  always @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      scl_q       <= 1'b1;
      sda_q       <= 1'b1;
      sel         <= 1'b0;
      state       <= ST_IDLE;
      bitcnt      <= 4'h0;
      shift       <= 8'h00;
      rdbuf       <= 8'h00;
      ptr         <= 16'h0000;
      stretch_cnt <= 15'h0000;
      wr_stb      <= 1'b0;
      wr_addr     <= 16'h0000;
      wr_data     <= 8'h00;
      o_sda_oe    <= 1'b0;
      o_sda_out   <= 1'b0;
      o_scl_oe    <= 1'b0;
      o_scl_out   <= 1'b0;
    end
    else
    begin
      scl_q  <= pin_s[0];
      sda_q  <= pin_s[1];
      sel    <= pin_s[2];
      wr_stb <= 1'b0;
      if (stretch_cnt != 15'h0000)
        stretch_cnt <= stretch_cnt - 15'h0001;
      if (stretch_cnt == 15'h0001)
        o_scl_oe <= 1'b0;
      if (start_c)
      begin
        state    <= ST_ADDR;
        // The clock fall that closes the start wraps the count to zero.
        bitcnt   <= 4'hf;
        o_sda_oe <= 1'b0;
      end
      else if (stop_c)
      begin
        state    <= ST_IDLE;
        o_sda_oe <= 1'b0;
      end
      else if (state != ST_IDLE && scl_rise)
      begin
        if (bitcnt < 4'h8)
          shift <= {shift[6:0], pin_s[1]};
        else if (state == ST_RDATA && pin_s[1])
          state <= ST_IDLE;
      end
      else if (state != ST_IDLE && scl_fall)
      begin
        if (bitcnt == 4'h7)
        begin
          bitcnt   <= 4'h8;
          o_sda_oe <= (state != ST_RDATA);
          case (state)
            ST_ADDR:
            begin
              if (!match)
              begin
                state    <= ST_IDLE;
                o_sda_oe <= 1'b0;
              end
            end
            ST_RA_HI:
              ptr[15:8] <= shift;
            ST_RA_LO:
              ptr[7:0] <= shift;
            ST_WDATA:
            begin
              wr_stb  <= 1'b1;
              wr_addr <= ptr;
              wr_data <= shift;
              ptr     <= ptr + 16'h0001;
            end
            default:
              o_sda_oe <= 1'b0;
          endcase
        end
        else if (bitcnt == 4'h8)
        begin
          bitcnt   <= 4'h0;
          o_sda_oe <= 1'b0;
          case (state)
            ST_ADDR:
            begin
              o_scl_oe    <= 1'b1;
              stretch_cnt <= i_deep_sleep_state ? P_DEEP_STRETCH_CYC
                                                : NORM_CYC;
              if (shift[0])
              begin
                state    <= ST_RDATA;
                o_sda_oe <= ~rd_byte[7];
                rdbuf    <= {rd_byte[6:0], 1'b0};
                ptr      <= ptr + 16'h0001;
              end
              else
                state <= ST_RA_HI;
            end
            ST_RA_HI:
              state <= ST_RA_LO;
            ST_RA_LO:
              state <= ST_WDATA;
            ST_WDATA:
              state <= ST_WDATA;
            ST_RDATA:
            begin
              o_sda_oe <= ~rd_byte[7];
              rdbuf    <= {rd_byte[6:0], 1'b0};
              ptr      <= ptr + 16'h0001;
            end
            default:
              state <= ST_IDLE;
          endcase
        end
        else
        begin
          bitcnt <= bitcnt + 4'h1;
          if (state == ST_RDATA)
          begin
            o_sda_oe <= ~rdbuf[7];
            rdbuf    <= {rdbuf[6:0], 1'b0};
          end
        end
      end
    end
  end

  // Register file and command pulses.
  always @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_system_settings          <= `HDI_RST_SETTINGS;
      o_thermal_limit_settings   <= `HDI_RST_THERMAL;
      o_bridge_setup             <= `HDI_RST_BRIDGE;
      o_pulse_rate_setting       <= `HDI_RST_PULSE;
      o_resonant_drive_frequency <= `HDI_RST_FREQ;
      o_resonance_tracking_setup <= `HDI_RST_TRACK;
      o_waveform_shape           <= `HDI_RST_SHAPE;
      o_trigger_pulse            <= 1'b0;
      o_stop_pulse               <= 1'b0;
      o_soft_reset_pulse         <= 1'b0;
      o_ack_reset_pulse          <= 1'b0;
    end
    else
    begin
      o_trigger_pulse    <= 1'b0;
      o_stop_pulse       <= 1'b0;
      o_soft_reset_pulse <= 1'b0;
      o_ack_reset_pulse  <= 1'b0;
      if (i_freq_upd)
        o_resonant_drive_frequency <= i_freq_meas;
      if (wr_stb)
      begin
        case (wr_addr)
          `HDI_OFS_SETTINGS:
            o_system_settings <= wr_data;
          `HDI_OFS_THERMAL:
            o_thermal_limit_settings <= wr_data;
          `HDI_OFS_CONTROL:
          begin
            o_soft_reset_pulse <= wr_data[`HDI_BIT_SOFT_RST];
            o_ack_reset_pulse  <= wr_data[`HDI_BIT_ACK_RST];
          end
          `HDI_OFS_HAPTIC:
          begin
            o_trigger_pulse <= wr_data[`HDI_BIT_TRIGGER];
            o_stop_pulse    <= wr_data[`HDI_BIT_STOP];
          end
          `HDI_OFS_BRIDGE:
            o_bridge_setup[7:0] <= wr_data;
          `HDI_OFS_BRIDGE + `HDI_OFS_HIGH:
            o_bridge_setup[15:8] <= wr_data;
          `HDI_OFS_PULSE:
            o_pulse_rate_setting[7:0] <= wr_data;
          `HDI_OFS_PULSE + `HDI_OFS_HIGH:
            o_pulse_rate_setting[15:8] <= wr_data;
          `HDI_OFS_FREQ:
            o_resonant_drive_frequency[7:0] <= wr_data;
          `HDI_OFS_FREQ + `HDI_OFS_HIGH:
            o_resonant_drive_frequency[15:8] <= wr_data;
          `HDI_OFS_TRACK:
            o_resonance_tracking_setup <= wr_data;
          `HDI_OFS_SHAPE:
            o_waveform_shape <= wr_data;
          default:
            o_waveform_shape <= o_waveform_shape;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- hdi_i2c_port_assertions.sv
// Concurrent checks on the haptic driver register port.
`timescale 1ns/10ps
`default_nettype none
module hdi_i2c_port_chk #(
  parameter [14:0] P_DEEP_STRETCH_CYC = 15'h4650
) (
  // Clock and reset.
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  // Bus pins.
  input  wire logic        i_scl,
  input  wire logic        o_scl_out,
  input  wire logic        o_scl_oe,
  input  wire logic        o_sda_out,
  input  wire logic        o_sda_oe,
  // Engine side.
  input  wire logic        i_wave_done,
  input  wire logic [15:0] i_freq_start,
  input  wire logic [15:0] i_freq_end,
  input  wire logic [7:0]  o_system_settings,
  input  wire logic [15:0] o_bridge_setup,
  input  wire logic        o_recal_flag
);
  localparam int LIM = P_DEEP_STRETCH_CYC > 3200 ? P_DEEP_STRETCH_CYC : 3200;
  logic [15:0] dif;
  logic        big;
  logic [15:0] run;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  // Drift test: four times the change against the start value.
  always @*
  begin
    if (i_freq_end > i_freq_start)
      dif = i_freq_end - i_freq_start;
    else
      dif = i_freq_start - i_freq_end;
    big = {dif, 2'b00} > {2'b00, i_freq_start};
  end
  // Length of the current clock stretch.
  always @(posedge i_clk_sys)
  begin
    if (i_rst || !o_scl_oe)
      run <= 16'h0000;
    else
      run <= run + 16'h0001;
  end
  chk_open_drain: assert property (!o_scl_out && !o_sda_out)
    else $error("pin output value not zero");
  chk_recal_sets: assert property (i_wave_done && big |=> o_recal_flag)
    else $error("flag not set after large drift");
  chk_recal_cause: assert property ($rose(o_recal_flag) |->
    $past(i_wave_done) && $past(big))
    else $error("flag set without large drift");
  chk_stretch_len: assert property ($fell(o_scl_oe) && !$past(i_rst) |->
    run == 16'd800 || run == {1'b0, P_DEEP_STRETCH_CYC})
    else $error("stretch length wrong");
  chk_stretch_max: assert property (run <= LIM)
    else $error("stretch too long");
  chk_sda_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data changed while clock high");
  chk_ack_after_fall: assert property ($rose(o_sda_oe) |->
    !$past(i_scl) && $past(i_scl, 6))
    else $error("data drive not after clock fall");
  chk_stretch_cause: assert property ($rose(o_scl_oe) |->
    !$past(i_scl) && $past(i_scl, 6))
    else $error("stretch not after clock fall");
  chk_reset_values: assert property ($fell(i_rst) |->
    o_system_settings == 8'h22 && o_bridge_setup == 16'h353e)
    else $error("register reset value wrong");
endmodule
bind hdi_i2c_port hdi_i2c_port_chk #(
  .P_DEEP_STRETCH_CYC(P_DEEP_STRETCH_CYC)
) chk_u (
  .i_clk_sys, .i_rst, .i_scl, .o_scl_out, .o_scl_oe, .o_sda_out,
  .o_sda_oe, .i_wave_done, .i_freq_start, .i_freq_end,
  .o_system_settings, .o_bridge_setup, .o_recal_flag
);
`default_nettype wire

//--- hdi_host.sv
// Bus controller model that drives the register port.
`timescale 1ns/10ps
`default_nettype none
module hdi_host (
  // Clock and bus lines.
  input  wire logic i_clk_sys,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output var logic  o_scl,
  output var logic  o_sda,
  output var logic  o_hang
);
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
    o_hang = 1'b0;
  end
  task automatic half;
    repeat (20) @(negedge i_clk_sys);
  endtask
  task automatic rise;
    int n;
    o_scl = 1'b1;
    n = 0;
    while (i_scl !== 1'b1 && n < 30000)
    begin
      @(negedge i_clk_sys);
      n++;
    end
    if (n == 30000)
      o_hang = 1'b1;
  endtask
  task automatic bit_io(input logic b, output logic s);
    o_sda = b;
    half();
    rise();
    half();
    s = i_sda;
    o_scl = 1'b0;
  endtask
  task automatic start;
    o_sda = 1'b1;
    half();
    rise();
    half();
    o_sda = 1'b0;
    half();
    o_scl = 1'b0;
  endtask
  task automatic stop;
    o_sda = 1'b0;
    half();
    rise();
    half();
    o_sda = 1'b1;
    half();
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic get(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(last, s);
  endtask
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking testbench for the haptic driver register port.
`timescale 1ns/10ps
`default_nettype none
`include "hdi_i2c_map.vh"
module testbench;
  logic        i_clk_sys = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_addr_sel = 1'b0, i_wave_done = 1'b0, i_freq_upd = 1'b0;
  logic        i_haptics_active = 1'b1, i_deep_sleep_state = 1'b0;
  logic        i_over_temp = 1'b1, i_over_cur = 1'b0, i_reset_flag = 1'b1;
  logic [15:0] i_freq_start = 16'h0064, i_freq_end = 16'h0064;
  logic [15:0] i_freq_meas = 16'h00c8;
  logic        o_scl_oe, o_sda_oe, o_recal_flag, o_trigger_pulse;
  logic        o_stop_pulse, o_soft_reset_pulse, o_ack_reset_pulse;
  logic [7:0]  o_system_settings, o_thermal_limit_settings;
  logic [7:0]  o_resonance_tracking_setup, o_waveform_shape;
  logic [15:0] o_bridge_setup, o_pulse_rate_setting;
  logic [15:0] o_resonant_drive_frequency;
  logic        scl_h, sda_h, hang;
  wire logic   scl_w, sda_w;
  logic [7:0]  ex [8];
  int          err_count = 0, comparisons = 0, st = 0, pc = 0;
  assign scl_w = scl_h & ~o_scl_oe;
  assign sda_w = sda_h & ~o_sda_oe;
  always #12.5 i_clk_sys = ~i_clk_sys;
  hdi_i2c_port #(.P_DEEP_STRETCH_CYC(15'h0064)) dut_u (
    .i_clk_sys, .i_rst, .i_scl(scl_w), .o_scl_out(), .o_scl_oe,
    .i_sda(sda_w), .o_sda_out(), .o_sda_oe, .i_addr_sel, .i_wave_done,
    .i_freq_start, .i_freq_end, .i_freq_upd, .i_freq_meas,
    .i_haptics_active, .i_deep_sleep_state, .i_over_temp, .i_over_cur,
    .i_reset_flag, .o_system_settings, .o_thermal_limit_settings,
    .o_bridge_setup, .o_pulse_rate_setting, .o_resonant_drive_frequency,
    .o_resonance_tracking_setup, .o_waveform_shape, .o_trigger_pulse,
    .o_stop_pulse, .o_soft_reset_pulse, .o_ack_reset_pulse, .o_recal_flag
  );
  hdi_host host_u (
    .i_clk_sys, .i_scl(scl_w), .i_sda(sda_w), .o_scl(scl_h),
    .o_sda(sda_h), .o_hang(hang)
  );
  always @(posedge i_clk_sys)
  begin
    st <= st + int'(o_scl_oe);
    pc <= pc + o_trigger_pulse + 4 * o_stop_pulse
      + 16 * o_ack_reset_pulse + 64 * o_soft_reset_pulse;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic give_verdict;
    $display("Checks %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic open(input logic [15:0] p);
    logic a;
    host_u.start();
    host_u.put({`HDI_ADDR_ONE, 1'b0}, a);
    chk(a, 1'b1);
    host_u.put(p[15:8], a);
    chk(a, 1'b1);
    host_u.put(p[7:0], a);
    chk(a, 1'b1);
  endtask
  task automatic wb(input logic [7:0] d);
    logic a;
    host_u.put(d, a);
    chk(a, 1'b1);
  endtask
  task automatic rd_n(input logic [15:0] p, input int n);
    logic a;
    logic [7:0] d;
    open(p);
    host_u.start();
    host_u.put({`HDI_ADDR_ONE, 1'b1}, a);
    chk(a, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      host_u.get(i == n - 1, d);
      chk(d, ex[i]);
    end
    host_u.stop();
  endtask
  task automatic t_reset;
    ex = '{8'h3e, 8'h35, 8'h20, 8'h4e, 8'haa, 8'h00, 8'h50, 8'hc0};
    rd_n(16'h3000, 8);
    ex = '{8'h5a, 8'h5a, 8'h01, 8'h00, 8'h00, 8'h00, 8'hee, 8'hee};
    rd_n(16'h0000, 8);
  endtask
  task automatic t_write;
    ex = '{8'h77, 8'h66, 8'h11, 8'h22, 8'h33, 8'h44, 8'haa, 8'h00};
    open(16'h2ffe);
    for (int i = 0; i < 6; i++)
      wb(ex[i]);
    host_u.stop();
    chk(o_bridge_setup, 16'h2211);
    chk(o_pulse_rate_setting, 16'h4433);
    chk(o_system_settings, 8'h22);
    ex = '{8'h11, 8'h22, 8'h33, 8'h44, 8'haa, 8'h00, 8'h00, 8'h00};
    rd_n(16'h3000, 5);
  endtask
  task automatic t_addr;
    logic a;
    logic [6:0] p;
    logic [6:0] q;
    for (int s = 0; s < 2; s++)
    begin
      i_addr_sel = s[0];
      repeat (8) @(negedge i_clk_sys);
      p = s ? `HDI_ADDR_TWO : `HDI_ADDR_ONE;
      q = s ? `HDI_ADDR_ONE : `HDI_ADDR_TWO;
      for (int k = 0; k < 3; k++)
      begin
        host_u.start();
        host_u.put({k == 2 ? q : p ^ k[6:0], 1'b0}, a);
        chk(a, k < 2);
        host_u.stop();
      end
    end
    i_addr_sel = 1'b0;
    repeat (8) @(negedge i_clk_sys);
  endtask
  task automatic wave(input logic [15:0] e, input logic x);
    i_freq_end = e;
    i_wave_done = 1'b1;
    @(negedge i_clk_sys);
    i_wave_done = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    chk(o_recal_flag, x);
  endtask
  task automatic t_recal;
    wave(16'd125, 1'b0);
    wave(16'd126, 1'b1);
    i_freq_upd = 1'b1;
    @(negedge i_clk_sys);
    i_freq_upd = 1'b0;
    ex = '{8'hc8, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    rd_n(16'h3004, 2);
    open(16'h3004);
    wb(8'hc8);
    wb(8'h00);
    host_u.stop();
    chk(o_recal_flag, 1'b0);
    chk(o_resonant_drive_frequency, 16'h00c8);
    wave(16'd110, 1'b0);
    wave(16'd90, 1'b0);
    wave(16'd74, 1'b1);
    ex[0] = 8'h27;
    rd_n(16'h1000, 1);
    open(16'h3005);
    wb(8'h00);
    host_u.stop();
    chk(o_recal_flag, 1'b0);
    wave(16'd75, 1'b0);
  endtask
  task automatic t_stretch;
    logic a;
    for (int d = 0; d < 2; d++)
    begin
      i_deep_sleep_state = d[0];
      st = 0;
      host_u.start();
      host_u.put({`HDI_ADDR_ONE, 1'b0}, a);
      host_u.stop();
      chk(st[15:0], d ? 16'd100 : 16'd800);
    end
    i_deep_sleep_state = 1'b0;
  endtask
  task automatic t_cmd;
    pc = 0;
    open(16'h2000);
    wb(8'h4b);
    wb(8'h15);
    wb(8'h03);
    wb(8'h03);
    host_u.stop();
    chk(pc[15:0], 16'h0055);
    chk(o_system_settings, 8'h4b);
    chk(o_thermal_limit_settings, 8'h15);
    open(16'h3006);
    wb(8'h5c);
    wb(8'h3d);
    host_u.stop();
    chk(o_resonance_tracking_setup, 8'h5c);
    chk(o_waveform_shape, 8'h3d);
  endtask
  initial
  begin
    repeat (12) @(negedge i_clk_sys);
    i_rst = 1'b0;
    repeat (4) @(negedge i_clk_sys);
    t_reset();
    t_write();
    t_addr();
    t_recal();
    t_stretch();
    t_cmd();
    give_verdict();
  end
  initial
  begin
    repeat (95000) @(posedge i_clk_sys);
    err_count++;
    give_verdict();
  end
  always @(posedge hang)
  begin
    err_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
